// >>> logic/pcs_test_pattern_fx_config.sv
// Top: jitter test pattern generator and checker plus FX sublayer configuration
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module pcs_test_pattern_fx_config #(
  parameter bit FRAME_PATTERNS   = 1'b1,  // Build option for selects 4 and 5
  parameter int HYST_UNIT_CYCLES = (pcs_tp_fx_pkg::HYST_UNIT_NS + pcs_tp_fx_pkg::CLK_PERIOD_NS - 1)
                                   / pcs_tp_fx_pkg::CLK_PERIOD_NS,
  parameter int HYST_BASE_CYCLES = (pcs_tp_fx_pkg::HYST_BASE_NS + pcs_tp_fx_pkg::CLK_PERIOD_NS - 1)
                                   / pcs_tp_fx_pkg::CLK_PERIOD_NS
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic      [7:0]  o_tx_byte,
  output logic             o_tx_is_k,
  output logic             o_tx_test_active,
  input  wire logic [7:0]  i_rx_byte,
  input  wire logic        i_rx_is_k,
  input  wire logic        i_rx_valid,
  input  wire logic        i_sd_serdes,
  input  wire logic        i_sd_external,
  input  wire logic        i_rx_fef_seen,
  output logic             o_fx_enabled,
  output logic             o_fx_signal_detect,
  output logic             o_fx_link_up,
  output logic             o_fx_tx_allow,
  output logic             o_fef_send,
  output logic             o_fef_detected
);
  // Software-visible configuration
  logic [2:0]  sel_q;        // Pattern select
  logic        detect_source_select_q;     // Detect source select
  logic        rsv25_q;      // Reserved, stored only
  logic        detect_input_enable_q;     // Detect input enable
  logic [3:0]  rsvhi_q;      // Reserved, stored only
  logic [3:0]  hyst_q;       // Hysteresis timer field
  logic        unidir_q;     // One-way transmit enable
  logic        fefchk_q;     // Far fault detect enable
  logic        fefgen_q;     // Far fault generate enable
  logic        fxena_q;      // Sublayer enable
  // Checker state
  logic [7:0]  errcnt_q;     // Pattern error counter
  logic        errflag_q;    // Pattern error flag
  logic        lock_q;       // Checker locked
  logic [3:0]  run_q;        // Consecutive matches or misses
  logic [7:0]  prev_byte_q;  // Previous received octet
  logic        prev_k_q;     // Previous octet was control
  // Generator state
  pcs_tp_fx_pkg::gen_state_t   gen_state_q;
  logic [10:0] gen_cnt_q;    // Octet index in gap or frame
  logic [7:0]  lfsr_q;       // Current random octet
  // Combinational helpers and the registered hysteresis flag
  pcs_tp_fx_pkg::pattern_sel_t sel_eff;
  logic [7:0]  lfsr_next;    // Generator next octet
  logic [7:0]  rx_predict;   // Checker expected octet
  logic [10:0] frame_len;    // Octets per frame for the mode
  logic        is_random;    // Frame-based mode active
  logic        mismatch;     // Received octet differs
  logic        check_en;     // Checker looks at this octet
  logic        err_event;    // Counted error
  logic        cnt_clear;    // Software zeroes the counter
  logic        sd_raw;       // Selected detect line
  logic        hyst_done;    // Hysteresis elapsed
  logic [19:0] hyst_target;  // Hysteresis length in cycles

  pcs_tp_byte_step u_gen_step (
    .i_byte (lfsr_q),
    .o_next (lfsr_next)
  );

  pcs_tp_byte_step u_chk_step (
    .i_byte (prev_byte_q),
    .o_next (rx_predict)
  );

  // Unsupported or removed selects fall back to off
  always_comb begin
    case (sel_q)
      pcs_tp_fx_pkg::PAT_HIGH:  sel_eff = pcs_tp_fx_pkg::PAT_HIGH;
      pcs_tp_fx_pkg::PAT_LOW:   sel_eff = pcs_tp_fx_pkg::PAT_LOW;
      pcs_tp_fx_pkg::PAT_MIXED: sel_eff = pcs_tp_fx_pkg::PAT_MIXED;
      pcs_tp_fx_pkg::PAT_LONG:  sel_eff = FRAME_PATTERNS ? pcs_tp_fx_pkg::PAT_LONG : pcs_tp_fx_pkg::PAT_OFF;
      pcs_tp_fx_pkg::PAT_SHORT: sel_eff = FRAME_PATTERNS ? pcs_tp_fx_pkg::PAT_SHORT : pcs_tp_fx_pkg::PAT_OFF;
      default: sel_eff = pcs_tp_fx_pkg::PAT_OFF;
    endcase
    is_random = (sel_eff == pcs_tp_fx_pkg::PAT_LONG) || (sel_eff == pcs_tp_fx_pkg::PAT_SHORT);
    frame_len = (sel_eff == pcs_tp_fx_pkg::PAT_LONG) ? pcs_tp_fx_pkg::LONG_PKT_BYTES
                                                     : pcs_tp_fx_pkg::SHORT_PKT_BYTES;
  end

  // Register writes; the counter clear is handled with the checker
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sel_q    <= pcs_tp_fx_pkg::RST_SEL;
      detect_source_select_q <= pcs_tp_fx_pkg::RST_DETECT_SOURCE_SELECT;
      rsv25_q  <= pcs_tp_fx_pkg::RST_RSV25;
      detect_input_enable_q <= pcs_tp_fx_pkg::RST_DETECT_INPUT_ENABLE;
      rsvhi_q  <= pcs_tp_fx_pkg::RST_RSVHI;
      hyst_q   <= pcs_tp_fx_pkg::RST_HYST;
      unidir_q <= pcs_tp_fx_pkg::RST_UNIDIR;
      fefchk_q <= pcs_tp_fx_pkg::RST_FEFCHK;
      fefgen_q <= pcs_tp_fx_pkg::RST_FEFGEN;
      fxena_q  <= pcs_tp_fx_pkg::RST_FXENA;
    end else if (i_wr && i_addr == pcs_tp_fx_pkg::TP_MODE_OFS) begin
      sel_q    <= i_wdata[pcs_tp_fx_pkg::SEL_MSB:pcs_tp_fx_pkg::SEL_LSB];
    end else if (i_wr && i_addr == pcs_tp_fx_pkg::FX_CFG_OFS) begin
      detect_source_select_q <= i_wdata[pcs_tp_fx_pkg::DETECT_SOURCE_SELECT_BIT];
      // Reserved bits stored as written; keeping them at reset is up to software
      rsv25_q  <= i_wdata[pcs_tp_fx_pkg::RSV25_BIT];
      detect_input_enable_q <= i_wdata[pcs_tp_fx_pkg::DETECT_INPUT_ENABLE_BIT];
      rsvhi_q  <= i_wdata[pcs_tp_fx_pkg::RSVHI_MSB:pcs_tp_fx_pkg::RSVHI_LSB];
      hyst_q   <= i_wdata[pcs_tp_fx_pkg::HYST_MSB:pcs_tp_fx_pkg::HYST_LSB];
      unidir_q <= i_wdata[pcs_tp_fx_pkg::UNIDIR_BIT];
      fefchk_q <= i_wdata[pcs_tp_fx_pkg::FEFCHK_BIT];
      fefgen_q <= i_wdata[pcs_tp_fx_pkg::FEFGEN_BIT];
      fxena_q  <= i_wdata[pcs_tp_fx_pkg::FXENA_BIT];
    end
  end

  // Read data one cycle after the strobe, zero otherwise and for unmapped addresses
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= '0;
      if (i_rd && i_addr == pcs_tp_fx_pkg::TP_MODE_OFS) begin
        o_rdata[pcs_tp_fx_pkg::SEL_MSB:pcs_tp_fx_pkg::SEL_LSB] <= sel_q;
      end else if (i_rd && i_addr == pcs_tp_fx_pkg::TP_STATUS_OFS) begin
        o_rdata[pcs_tp_fx_pkg::ERRCNT_MSB:pcs_tp_fx_pkg::ERRCNT_LSB] <= errcnt_q;
        o_rdata[pcs_tp_fx_pkg::ERRFLAG_BIT] <= errflag_q;
        o_rdata[pcs_tp_fx_pkg::LOCK_BIT]    <= lock_q;
      end else if (i_rd && i_addr == pcs_tp_fx_pkg::FX_CFG_OFS) begin
        o_rdata[pcs_tp_fx_pkg::DETECT_SOURCE_SELECT_BIT] <= detect_source_select_q;
        o_rdata[pcs_tp_fx_pkg::RSV25_BIT]  <= rsv25_q;
        o_rdata[pcs_tp_fx_pkg::DETECT_INPUT_ENABLE_BIT] <= detect_input_enable_q;
        o_rdata[pcs_tp_fx_pkg::RSVHI_MSB:pcs_tp_fx_pkg::RSVHI_LSB] <= rsvhi_q;
        o_rdata[pcs_tp_fx_pkg::HYST_MSB:pcs_tp_fx_pkg::HYST_LSB]   <= hyst_q;
        o_rdata[pcs_tp_fx_pkg::UNIDIR_BIT] <= unidir_q;
        o_rdata[pcs_tp_fx_pkg::FEFCHK_BIT] <= fefchk_q;
        o_rdata[pcs_tp_fx_pkg::FEFGEN_BIT] <= fefgen_q;
        o_rdata[pcs_tp_fx_pkg::FXENA_BIT]  <= fxena_q;
      end
    end
  end

  // Random frame sequencer: gap of idles, then a frame of chained octets
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gen_state_q <= pcs_tp_fx_pkg::GEN_OFF;
      gen_cnt_q   <= '0;
      lfsr_q      <= pcs_tp_fx_pkg::LFSR_SEED;
    end else if (!is_random) begin
      gen_state_q <= pcs_tp_fx_pkg::GEN_OFF;
      gen_cnt_q   <= '0;
    end else begin
      case (gen_state_q)
        pcs_tp_fx_pkg::GEN_OFF: begin
          gen_state_q <= pcs_tp_fx_pkg::GEN_GAP;
          gen_cnt_q   <= '0;
        end
        pcs_tp_fx_pkg::GEN_GAP: begin
          if (gen_cnt_q == pcs_tp_fx_pkg::GAP_BYTES - 11'h001) begin
            gen_state_q <= pcs_tp_fx_pkg::GEN_FRAME;
            gen_cnt_q   <= '0;
          end else begin
            gen_cnt_q   <= gen_cnt_q + 11'h001;
          end
        end
        pcs_tp_fx_pkg::GEN_FRAME: begin
          // Chain never restarts so the checker can follow across frames
          lfsr_q <= lfsr_next;
          if (gen_cnt_q == frame_len - 11'h001) begin
            gen_state_q <= pcs_tp_fx_pkg::GEN_GAP;
            gen_cnt_q   <= '0;
          end else begin
            gen_cnt_q   <= gen_cnt_q + 11'h001;
          end
        end
        default: begin
          gen_state_q <= pcs_tp_fx_pkg::GEN_OFF;
          gen_cnt_q   <= '0;
        end
      endcase
    end
  end

  // Transmit code group, one per clock
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tx_byte        <= '0;
      o_tx_is_k        <= 1'b0;
      o_tx_test_active <= 1'b0;
    end else begin
      o_tx_test_active <= (sel_eff != pcs_tp_fx_pkg::PAT_OFF);
      case (sel_eff)
        pcs_tp_fx_pkg::PAT_HIGH: begin
          o_tx_byte <= pcs_tp_fx_pkg::CG_D21_5;
          o_tx_is_k <= 1'b0;
        end
        pcs_tp_fx_pkg::PAT_LOW: begin
          o_tx_byte <= pcs_tp_fx_pkg::CG_K28_7;
          o_tx_is_k <= 1'b1;
        end
        pcs_tp_fx_pkg::PAT_MIXED: begin
          o_tx_byte <= pcs_tp_fx_pkg::CG_K28_5;
          o_tx_is_k <= 1'b1;
        end
        pcs_tp_fx_pkg::PAT_LONG, pcs_tp_fx_pkg::PAT_SHORT: begin
          // Frame octets are data, gaps are comma idles
          o_tx_byte <= (gen_state_q == pcs_tp_fx_pkg::GEN_FRAME) ? lfsr_q : pcs_tp_fx_pkg::CG_K28_5;
          o_tx_is_k <= (gen_state_q != pcs_tp_fx_pkg::GEN_FRAME);
        end
        default: begin
          o_tx_byte <= '0;
          o_tx_is_k <= 1'b0;
        end
      endcase
    end
  end

  // Expected octet comparison; random frames are predicted from the last octet
  always_comb begin
    case (sel_eff)
      pcs_tp_fx_pkg::PAT_HIGH:  mismatch = i_rx_is_k || (i_rx_byte != pcs_tp_fx_pkg::CG_D21_5);
      pcs_tp_fx_pkg::PAT_LOW:   mismatch = !i_rx_is_k || (i_rx_byte != pcs_tp_fx_pkg::CG_K28_7);
      pcs_tp_fx_pkg::PAT_MIXED: mismatch = !i_rx_is_k || (i_rx_byte != pcs_tp_fx_pkg::CG_K28_5);
      pcs_tp_fx_pkg::PAT_LONG, pcs_tp_fx_pkg::PAT_SHORT: begin
        if (i_rx_is_k) begin
          mismatch = (i_rx_byte != pcs_tp_fx_pkg::CG_K28_5);
        end else if (prev_k_q) begin
          mismatch = 1'b0; // First frame octet seeds the prediction
        end else begin
          mismatch = (i_rx_byte != rx_predict);
        end
      end
      default:  mismatch = 1'b0;
    endcase
    check_en  = i_rx_valid && (sel_eff != pcs_tp_fx_pkg::PAT_OFF);
    err_event = check_en && mismatch && lock_q;
    cnt_clear = i_wr && (i_addr == pcs_tp_fx_pkg::TP_STATUS_OFS)
                && (i_wdata[pcs_tp_fx_pkg::ERRCNT_MSB:pcs_tp_fx_pkg::ERRCNT_LSB] == 8'h00);
  end

  // Lock: enough good octets in a row to lock, enough bad in a row to drop
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lock_q      <= 1'b0;
      run_q       <= '0;
      prev_byte_q <= '0;
      prev_k_q    <= 1'b1;
    end else if (sel_eff == pcs_tp_fx_pkg::PAT_OFF) begin
      lock_q <= 1'b0;
      run_q  <= '0;
    end else if (i_rx_valid) begin
      prev_byte_q <= i_rx_byte;
      prev_k_q    <= i_rx_is_k;
      if (lock_q == mismatch) begin
        // Locked and missing, or unlocked and matching: count toward a change
        if (run_q == (lock_q ? pcs_tp_fx_pkg::LOSS_ERRORS : pcs_tp_fx_pkg::LOCK_MATCHES) - 4'h1) begin
          lock_q <= !lock_q;
          run_q  <= '0;
        end else begin
          run_q  <= run_q + 4'h1;
        end
      end else begin
        run_q <= '0;
      end
    end
  end

  // Error counter and flag; a counted error wins over a clear in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      errcnt_q  <= '0;
      errflag_q <= 1'b0;
    end else if (err_event) begin
      errflag_q <= 1'b1;
      if (cnt_clear) begin
        errcnt_q <= 8'h01;
      end else if (errcnt_q != pcs_tp_fx_pkg::ERRCNT_MAX) begin
        errcnt_q <= errcnt_q + 8'h01;
      end
    end else if (cnt_clear) begin
      errcnt_q  <= '0;
      errflag_q <= 1'b0;
    end
  end

  // Detect source selection and hysteresis length
  always_comb begin
    sd_raw      = detect_source_select_q ? i_sd_external : i_sd_serdes;
    hyst_target = 20'(int'(hyst_q) * HYST_UNIT_CYCLES + HYST_BASE_CYCLES);
  end

  pcs_fx_hyst_timer #(
    .CNT_W (20)
  ) u_hyst (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_level   (o_fx_signal_detect),
    .i_target  (hyst_target),
    .o_done    (hyst_done)
  );

  // FX sublayer status and transmit gating, all quiet while disabled
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_fx_enabled       <= 1'b0;
      o_fx_signal_detect <= 1'b0;
      o_fx_link_up       <= 1'b0;
      o_fx_tx_allow      <= 1'b0;
      o_fef_send         <= 1'b0;
      o_fef_detected     <= 1'b0;
    end else begin
      o_fx_enabled       <= fxena_q;
      o_fx_signal_detect <= fxena_q && (!detect_input_enable_q || sd_raw);
      o_fx_link_up       <= fxena_q && hyst_done;
      o_fx_tx_allow      <= fxena_q && (o_fx_link_up || unidir_q);
      // Far fault is sent while the receive link is down
      o_fef_send         <= fxena_q && fefgen_q && !o_fx_link_up;
      o_fef_detected     <= fxena_q && fefchk_q && i_rx_fef_seen;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_long_mid;
    sel_eff == pcs_tp_fx_pkg::PAT_LONG && gen_state_q == pcs_tp_fx_pkg::GEN_FRAME
      && gen_cnt_q != pcs_tp_fx_pkg::LONG_PKT_BYTES - 11'h001;
  endsequence

  a_off_no_tx: assert property (sel_eff == pcs_tp_fx_pkg::PAT_OFF |=> !o_tx_test_active)
    else $error("test pattern active while off");
  a_high_pattern: assert property ($past(sel_eff) == pcs_tp_fx_pkg::PAT_HIGH |-> o_tx_byte == pcs_tp_fx_pkg::CG_D21_5 && !o_tx_is_k)
    else $error("high pattern wrong");
  a_low_pattern: assert property ($past(sel_eff) == pcs_tp_fx_pkg::PAT_LOW |-> o_tx_byte == pcs_tp_fx_pkg::CG_K28_7 && o_tx_is_k)
    else $error("low pattern wrong");
  a_mixed_pattern: assert property ($past(sel_eff) == pcs_tp_fx_pkg::PAT_MIXED |-> o_tx_byte == pcs_tp_fx_pkg::CG_K28_5 && o_tx_is_k)
    else $error("mixed pattern wrong");
  a_long_frame: assert property (s_long_mid ##1 sel_eff == pcs_tp_fx_pkg::PAT_LONG |-> gen_state_q == pcs_tp_fx_pkg::GEN_FRAME)
    else $error("long frame ended early");
  a_cnt_saturate: assert property (errcnt_q == pcs_tp_fx_pkg::ERRCNT_MAX && err_event && !cnt_clear |=> errcnt_q == pcs_tp_fx_pkg::ERRCNT_MAX)
    else $error("error counter wrapped");
  a_cnt_clear: assert property (cnt_clear && !err_event |=> errcnt_q == 8'h00)
    else $error("error counter not cleared");
  a_err_flag: assert property (err_event |=> errflag_q && errcnt_q != 8'h00)
    else $error("error flag not set");
  a_count_step: assert property (err_event && !cnt_clear && errcnt_q != pcs_tp_fx_pkg::ERRCNT_MAX |=> errcnt_q == $past(errcnt_q) + 8'h01)
    else $error("error not counted once");
  a_unlock_off: assert property (sel_eff == pcs_tp_fx_pkg::PAT_OFF |=> !lock_q)
    else $error("locked while off");
  a_sd_forced: assert property (fxena_q && !detect_input_enable_q |=> o_fx_signal_detect)
    else $error("signal detect not forced");
  a_one_way: assert property (fxena_q && unidir_q |=> o_fx_tx_allow)
    else $error("one-way transmit blocked");
  a_disabled_quiet: assert property (!fxena_q |=> !o_fx_link_up && !o_fx_tx_allow && !o_fef_send)
    else $error("sublayer active while disabled");
endmodule : pcs_test_pattern_fx_config
`default_nettype wire

// >>> logic/pcs_tp_fx_pkg.sv
// Constants, field layout and encodings for the test pattern and FX sublayer block
// Summary of operation
// - Select field zero disables pattern transmission
// - Select 1 repeats D21.5 code group
// - Select 2 repeats K28.7 code group
// - Select 3 repeats K28.5 code group
// - Select 4 sends 1524-byte random frames
// - Select 5 sends 360-byte random frames
// - Frame patterns removable by build option
// - Error counter saturates, zero write clears
// - Error bit shows checker found error
// - Lock bit shows checker locked
// - Detect source: serdes or external line
// - Detect enable zero forces signal present
// - Hysteresis lasts timer times 65536ns plus 2320ns
// - Hysteresis timer field resets to five
// - One-way mode allows transmit regardless
// - Far fault detect enable, resets on
// - Far fault generate enable, resets on
// - Sublayer runs only when enabled
`default_nettype none
package pcs_tp_fx_pkg;
  // Register byte offsets
  localparam logic [7:0] TP_MODE_OFS   = 8'h00;
  localparam logic [7:0] TP_STATUS_OFS = 8'h04;
  localparam logic [7:0] FX_CFG_OFS    = 8'h08;
  // Field positions
  localparam int SEL_LSB     = 0;
  localparam int SEL_MSB     = 2;
  localparam int ERRCNT_LSB  = 8;
  localparam int ERRCNT_MSB  = 15;
  localparam int ERRFLAG_BIT = 4;
  localparam int LOCK_BIT    = 0;
  localparam int DETECT_SOURCE_SELECT_BIT  = 26;
  localparam int RSV25_BIT   = 25;
  localparam int DETECT_INPUT_ENABLE_BIT  = 24;
  localparam int RSVHI_LSB   = 12;
  localparam int RSVHI_MSB   = 15;
  localparam int HYST_LSB    = 4;
  localparam int HYST_MSB    = 7;
  localparam int UNIDIR_BIT  = 3;
  localparam int FEFCHK_BIT  = 2;
  localparam int FEFGEN_BIT  = 1;
  localparam int FXENA_BIT   = 0;
  // Reset values
  localparam logic [2:0] RST_SEL    = 3'h0;
  localparam logic       RST_DETECT_SOURCE_SELECT = 1'b0;
  localparam logic       RST_RSV25  = 1'b1;
  localparam logic       RST_DETECT_INPUT_ENABLE = 1'b1;
  localparam logic [3:0] RST_RSVHI  = 4'h4;
  localparam logic [3:0] RST_HYST   = 4'h5;
  localparam logic       RST_UNIDIR = 1'b0;
  localparam logic       RST_FEFCHK = 1'b1;
  localparam logic       RST_FEFGEN = 1'b1;
  localparam logic       RST_FXENA  = 1'b0;
  // Pattern select encodings
  typedef enum logic [2:0] {
    PAT_OFF   = 3'h0,
    PAT_HIGH  = 3'h1,
    PAT_LOW   = 3'h2,
    PAT_MIXED = 3'h3,
    PAT_LONG  = 3'h4,
    PAT_SHORT = 3'h5
  } pattern_sel_t;
  // Random frame generator states, Gray along off, gap, frame
  typedef enum logic [1:0] {
    GEN_OFF   = 2'h0,
    GEN_GAP   = 2'h1,
    GEN_FRAME = 2'h3
  } gen_state_t;
  // Code group octets before 8b10b encoding
  localparam logic [7:0] CG_D21_5 = 8'hB5;
  localparam logic [7:0] CG_K28_7 = 8'hFC;
  localparam logic [7:0] CG_K28_5 = 8'hBC;
  // Random frame shape
  localparam logic [10:0] LONG_PKT_BYTES  = 11'h5F4;
  localparam logic [10:0] SHORT_PKT_BYTES = 11'h168;
  localparam logic [10:0] GAP_BYTES       = 11'h00C;
  localparam logic [7:0]  LFSR_SEED       = 8'hFF;
  localparam logic [7:0]  LFSR_TAPS       = 8'hB8;
  // Checker lock hysteresis
  localparam logic [3:0] LOCK_MATCHES = 4'h8;
  localparam logic [3:0] LOSS_ERRORS  = 4'h4;
  localparam logic [7:0] ERRCNT_MAX   = 8'hFF;
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int HYST_UNIT_NS  = 65536;
  localparam int HYST_BASE_NS  = 2320;
endpackage : pcs_tp_fx_pkg
`default_nettype wire

// >>> logic/pcs_tp_byte_step.sv
// Next-octet function of the self-synchronising random pattern
`timescale 1ns/1ps
`default_nettype none
module pcs_tp_byte_step (
  input  wire logic [7:0] i_byte,
  output logic      [7:0] o_next
);
  // Shift left with parity of tapped bits; a nonzero octet never maps to zero
  always_comb begin
    o_next = {i_byte[6:0], ^(i_byte & pcs_tp_fx_pkg::LFSR_TAPS)};
  end
endmodule : pcs_tp_byte_step
`default_nettype wire

// >>> logic/pcs_fx_hyst_timer.sv
// Link hysteresis timer: signal must hold for the target count before link up
`timescale 1ns/1ps
`default_nettype none
module pcs_fx_hyst_timer #(
  parameter int CNT_W = 20
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_level,   // Qualified signal present
  input  wire logic [CNT_W-1:0] i_target,  // Cycles the level must hold
  output logic                  o_done     // Level has held long enough
);
  logic [CNT_W-1:0] cnt_q;  // Cycles of continuous level

  // Any drop restarts the count, so glitches never bring the link up
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q  <= '0;
      o_done <= 1'b0;
    end else if (!i_level) begin
      cnt_q  <= '0;
      o_done <= 1'b0;
    end else if (cnt_q >= i_target) begin
      o_done <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  a_done_after_hold: assert property ($rose(o_done) |-> $past(cnt_q) >= $past(i_target) && $past(i_level))
    else $error("link up before hysteresis elapsed");
endmodule : pcs_fx_hyst_timer
`default_nettype wire

// >>> bench/link_partner_model.sv
// Far-end link partner: echoes each code group back, can corrupt one
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
  input  wire logic       i_clk,
  input  wire logic       i_corrupt,
  input  wire logic [7:0] i_tx_byte,
  input  wire logic       i_tx_is_k,
  output var logic  [7:0] o_rx_byte,
  output var logic        o_rx_is_k,
  output var logic        o_rx_valid
);
  // Known values from time zero
  initial begin
    o_rx_byte  = 8'h00;
    o_rx_is_k  = 1'b0;
    o_rx_valid = 1'b0;
  end
  // One octet a cycle; inversion models a line error
  always @(posedge i_clk) begin
    o_rx_byte  <= i_corrupt ? ~i_tx_byte : i_tx_byte;
    o_rx_is_k  <= i_tx_is_k;
    o_rx_valid <= 1'b1;
  end
endmodule : link_partner_model
`default_nettype wire

// >>> bench/pcs_test_pattern_fx_config_test.sv
// Self-checking bench for the test pattern and FX configuration block
`timescale 1ns/1ps
`default_nettype none
module pcs_test_pattern_fx_config_test;
  logic        clk = 1'b0;         // 40 MHz reference
  logic        rst_n = 1'b0;       // Active low reset
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        sd_ser = 1'b0;
  logic        sd_ext = 1'b0;
  logic        fef_in = 1'b0;
  logic        corrupt = 1'b0;
  logic [31:0] rdata;
  logic [7:0]  tx_byte, rx_byte;
  logic        tx_k, tx_act, rx_k, rx_vld, fx_en, fx_sd, fx_up, fx_allow, fef_snd, fef_det;
  logic [31:0] exp_q[$];           // Expected read data, oldest first
  logic        rd_seen = 1'b0;     // Read taken last edge
  logic [2:0]  sels[5] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h0};
  logic [9:0]  exp_tx[5] = '{10'h2B5, 10'h3FC, 10'h3BC, 10'h000, 10'h000};
  int          err_total = 0;
  int          total_checks = 0;
  int          h;
  int          n;
  // Free-running clock
  always #12.5 clk = ~clk;
  // Short hysteresis units keep the run brief
  pcs_test_pattern_fx_config #(.HYST_UNIT_CYCLES(4), .HYST_BASE_CYCLES(2)) uut (
    .i_ref_clk(clk), .i_resetn(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_tx_byte(tx_byte), .o_tx_is_k(tx_k), .o_tx_test_active(tx_act),
    .i_rx_byte(rx_byte), .i_rx_is_k(rx_k), .i_rx_valid(rx_vld), .i_sd_serdes(sd_ser),
    .i_sd_external(sd_ext), .i_rx_fef_seen(fef_in), .o_fx_enabled(fx_en),
    .o_fx_signal_detect(fx_sd), .o_fx_link_up(fx_up), .o_fx_tx_allow(fx_allow),
    .o_fef_send(fef_snd), .o_fef_detected(fef_det));
  // Loopback partner on the line side
  link_partner_model partner (.i_clk(clk), .i_corrupt(corrupt), .i_tx_byte(tx_byte),
    .i_tx_is_k(tx_k), .o_rx_byte(rx_byte), .o_rx_is_k(rx_k), .o_rx_valid(rx_vld));
  // Verdict and end of run
  task automatic conclude;
    if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  // One comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One strobe cycle, then idle; the gap avoids double drives
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  // Read with its expectation noted
  task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd_exp
  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen) chk(rdata, exp_q.pop_front());
    rd_seen <= rd;
  end
  // Main sequence
  initial begin
    void'($urandom(32'hA52A));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_exp(8'h00, 32'h0);
    rd_exp(8'h04, 32'h0);
    rd_exp(8'h08, 32'h0300_4056);
    rd_exp(8'h0C, 32'h0);
    foreach (sels[i]) begin
      bus(1'b1, 8'h00, 32'(sels[i]));
      repeat (2) @(negedge clk);
      chk(32'({tx_act, tx_k, tx_byte}), 32'(exp_tx[i]));
    end
    // Random frames: idles, then seed octet as data
    for (int s = 4; s < 6; s++) begin
      // The chain holds its place between modes; a second reset brings back the seed
      if (s == 5) begin
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
      end
      bus(1'b1, 8'h00, 32'(s));
      repeat (2) @(negedge clk);
      for (n = 0; n < 40 && tx_k !== 1'b0; n++) @(negedge clk);
      if (tx_k !== 1'b0) begin
        err_total++;
        conclude();
      end
      chk(32'({tx_act, tx_k, tx_byte}), 32'h2FF);
      bus(1'b1, 8'h00, 32'h0);
    end
    // Checker lock, one line error, clear by zero write
    bus(1'b1, 8'h00, 32'h1);
    repeat (16) @(posedge clk);
    rd_exp(8'h04, 32'h1);
    corrupt <= 1'b1;
    @(posedge clk);
    corrupt <= 1'b0;
    repeat (4) @(posedge clk);
    rd_exp(8'h04, 32'h0111);
    bus(1'b1, 8'h04, 32'h0);
    rd_exp(8'h04, 32'h1);
    // Sublayer with a random hysteresis field
    h = $urandom % 4;
    sd_ser <= 1'b1;
    bus(1'b1, 8'h08, 32'h0300_4007 | 32'(h << 4));
    repeat (2) @(negedge clk);
    chk(32'({fx_en, fef_snd, fx_up}), 32'h6);
    for (n = 0; n < h * 4 + 8 && fx_up !== 1'b1; n++) @(negedge clk);
    if (fx_up !== 1'b1) begin
      err_total++;
      conclude();
    end
    chk(32'(fx_up), 32'h1);
    bus(1'b1, 8'h08, 32'h0700_400F);
    // Detect, timer, link and far fault each add one stage
    repeat (5) @(negedge clk);
    chk(32'({fx_sd, fx_up, fx_allow, fef_snd}), 32'h3);
    @(posedge clk);
    fef_in <= 1'b1;
    // Selected line low, so only the forcing can show a signal
    sd_ser <= 1'b0;
    bus(1'b1, 8'h08, 32'h0200_4005);
    repeat (4) @(negedge clk);
    chk(32'({fx_sd, fef_det}), 32'h3);
    bus(1'b1, 8'h08, 32'h0300_4006);
    repeat (3) @(negedge clk);
    chk(32'({fx_en, fx_sd, fx_up, fx_allow, fef_snd, fef_det}), 32'h0);
    rd_exp(8'h08, 32'h0300_4006);
    repeat (3) @(posedge clk);
    conclude();
  end
endmodule : pcs_test_pattern_fx_config_test
`default_nettype wire
